// ---- verilog/uart_modem_irq_baud.sv ----
// Modem control, modem status, interrupt ranking and baud divider.
// Assumes an 8-bit strobed host bus in the CLK domain; modem pins
// are asynchronous and are synchronised here.
`timescale 1ns/100ps
module uart_modem_irq_baud #(
    parameter int DEPTH = uart_modem_pkg::FIFO_DEPTH
) (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [2:0] ADDR,
    input  wire logic       RD_N,
    input  wire logic       WR_N,
    input  wire logic [7:0] DIN,
    output logic      [7:0] DOUT,
    output logic            DOUT_EN,
    input  wire logic       CTS_N,
    input  wire logic       DSR_N,
    input  wire logic       RI_N,
    input  wire logic       DCD_N,
    output logic            DTR_N,
    output logic            RTS_N,
    output logic            FIRST_USER_OUTPUT_N,
    output logic            SECOND_USER_OUTPUT_N,
    output logic            INTR,
    output logic            BAUD_TICK,
    input  wire logic       SERIAL_INPUT,
    output logic            SERIAL_OUTPUT,
    output logic            LOOP_SERIAL,
    input  wire logic       TX_SHIFT_OUT,
    output logic      [7:0] TX_DATA,
    output logic            TX_VALID,
    input  wire logic       TX_READY,
    input  wire logic       TX_DONE,
    input  wire logic       RX_AVAIL,
    input  wire logic [7:0] RX_DATA,
    input  wire logic [3:0] RX_ERR,
    output logic            RX_READ
);
    initial begin
        if (DEPTH < 2)
            $error("DEPTH too small");
    end
    typedef struct packed {
        logic [7:0]  mctl;
        logic [7:0]  ien;
        logic [7:0]  lctl;
        logic [7:0]  scr;
        logic [15:0] div;
        logic [15:0] cnt;
        logic        tick;
        logic [3:0]  dmsr;
        logic [3:0]  lerr;
        logic        thre;
        logic        thre_irq;
        logic        rx_sw;
        logic [11:0] sync;
        logic [3:0]  mprev;
        logic [2:0]  rd_s;
        logic [2:0]  wr_s;
        logic [7:0]  dout;
        logic        dout_en;
        logic        intr;
        logic [3:0]  mout_n;
        logic        serial_output;
        logic        rx_read;
        logic        loopser;
    } state_t;
    state_t st_r, st_nxt;
    fifo_if #(.W(8)) txq ();
    byte_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
        .CLK  (CLK),
        .RST  (RST),
        .port (txq.fifo)
    );
    logic       loopb, rd_p, wr_p, divsel, rx_flag;
    logic [3:0] mins, pins, chg;
    logic [2:0] pend;
    logic       any_pend, msr_pend;
    logic [1:0] top_id;
    logic [7:0] rdat;
    // ====================================================
    // Bus strobes, sources and ranking
    always_comb begin
        loopb  = st_r.mctl[uart_modem_pkg::MC_LOOP];
        divsel = st_r.lctl[uart_modem_pkg::LC_DIVSEL];
        rd_p   = st_r.rd_s[2] && !st_r.rd_s[1];
        wr_p   = st_r.wr_s[2] && !st_r.wr_s[1];
        // Pin levels as cts, dsr, ri, dcd, active high; settle on 2 = 3
        pins = st_r.mprev;
        for (int i = 0; i < 4; i++) begin
            if (st_r.sync[4+i] == st_r.sync[8+i])
                pins[i] = !st_r.sync[8+i];
        end
        // Loopback order: rts, dtr, first_user_output, second_user_output
        mins = loopb ? {st_r.mctl[3], st_r.mctl[2],
                        st_r.mctl[0], st_r.mctl[1]} : pins;
        chg = {mins[3] ^ st_r.mprev[3], st_r.mprev[2] && !mins[2],
               mins[1] ^ st_r.mprev[1], mins[0] ^ st_r.mprev[0]};
        rx_flag  = RX_AVAIL || st_r.rx_sw;
        msr_pend = |st_r.dmsr;
        pend = {|st_r.lerr && st_r.ien[2], rx_flag && st_r.ien[0],
                st_r.thre_irq && st_r.ien[1]};
        any_pend = |pend || (msr_pend && st_r.ien[3]);
        if (pend[2])
            top_id = uart_modem_pkg::ID_LINE;
        else if (pend[1])
            top_id = uart_modem_pkg::ID_RXD;
        else if (pend[0])
            top_id = uart_modem_pkg::ID_THRE;
        else
            top_id = uart_modem_pkg::ID_MODEM;
        case (ADDR)
            uart_modem_pkg::OFF_DATA:
                rdat = divsel ? st_r.div[7:0] : RX_DATA;
            uart_modem_pkg::OFF_IEN:
                rdat = divsel ? st_r.div[15:8] : {4'h0, st_r.ien[3:0]};
            uart_modem_pkg::OFF_IID:
                rdat = {5'h00, top_id, !any_pend};
            uart_modem_pkg::OFF_LCTL:  rdat = st_r.lctl;
            uart_modem_pkg::OFF_MCTL:  rdat = {3'h0, st_r.mctl[4:0]};
            uart_modem_pkg::OFF_LSTAT:
                rdat = {1'b0, st_r.thre && txq.out_valid == 1'b0,
                        st_r.thre, st_r.lerr, rx_flag};
            uart_modem_pkg::OFF_MSTAT:
                rdat = {mins[3], mins[2], mins[1], mins[0],
                        st_r.dmsr};
            default: rdat = st_r.scr;
        endcase
    end
    // ====================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.sync  = {st_r.sync[7:0], !DCD_N, !RI_N, !DSR_N, !CTS_N};
        st_nxt.sync[3:0] = {DCD_N, RI_N, DSR_N, CTS_N};
        st_nxt.rd_s  = {st_r.rd_s[1:0], RD_N};
        st_nxt.wr_s  = {st_r.wr_s[1:0], WR_N};
        st_nxt.mprev = mins;
        st_nxt.rx_read = 1'b0;
        st_nxt.dmsr  = st_r.dmsr;
        if (rd_p && ADDR == uart_modem_pkg::OFF_MSTAT)
            st_nxt.dmsr = 4'h0;
        st_nxt.dmsr = st_nxt.dmsr | chg;
        if (rd_p && ADDR == uart_modem_pkg::OFF_LSTAT)
            st_nxt.lerr = 4'h0;
        st_nxt.lerr = st_nxt.lerr | RX_ERR;
        if (rd_p && ADDR == uart_modem_pkg::OFF_IID
            && top_id == uart_modem_pkg::ID_THRE && pend == 3'b001)
            st_nxt.thre_irq = 1'b0;
        if (rd_p && ADDR == uart_modem_pkg::OFF_DATA && !divsel) begin
            st_nxt.rx_read = RX_AVAIL;
            st_nxt.rx_sw   = 1'b0;
        end
        if (TX_DONE && !txq.out_valid) begin
            st_nxt.thre     = 1'b1;
            st_nxt.thre_irq = 1'b1;
        end
        if (wr_p) begin
            case (ADDR)
                uart_modem_pkg::OFF_DATA:
                    if (divsel) begin
                        st_nxt.div[7:0] = DIN;
                        st_nxt.cnt = {st_r.div[15:8], DIN};
                    end else if (txq.in_ready) begin
                        st_nxt.thre     = 1'b0;
                        st_nxt.thre_irq = 1'b0;
                    end
                uart_modem_pkg::OFF_IEN:
                    if (divsel) begin
                        st_nxt.div[15:8] = DIN;
                        st_nxt.cnt = {DIN, st_r.div[7:0]};
                    end else
                        st_nxt.ien = {4'h0, DIN[3:0]};
                uart_modem_pkg::OFF_LCTL:  st_nxt.lctl = DIN;
                uart_modem_pkg::OFF_MCTL:  st_nxt.mctl = {3'h0, DIN[4:0]};
                uart_modem_pkg::OFF_LSTAT:
                    if (loopb) begin
                        st_nxt.lerr  = DIN[4:1];
                        st_nxt.rx_sw = DIN[0];
                        st_nxt.thre  = DIN[5];
                        st_nxt.thre_irq = DIN[5];
                    end
                uart_modem_pkg::OFF_MSTAT:
                    if (loopb)
                        st_nxt.dmsr = DIN[3:0];
                uart_modem_pkg::OFF_SCR:   st_nxt.scr = DIN;
                default: st_nxt.scr = st_r.scr;
            endcase
        end
        // Divider, reload wins over count
        st_nxt.tick = 1'b0;
        if (!(wr_p && divsel && ADDR[2:1] == 2'b00)) begin
            if (st_r.cnt <= 16'h0001) begin
                st_nxt.cnt  = (st_r.div == 16'h0000) ? 16'h0001 : st_r.div;
                st_nxt.tick = 1'b1;
            end else
                st_nxt.cnt = st_r.cnt - 16'h0001;
        end
        if (rd_p)
            st_nxt.dout = rdat;
        st_nxt.dout_en = !st_r.rd_s[1];
        st_nxt.intr = any_pend && st_r.mctl[uart_modem_pkg::MC_SECOND_USER_OUTPUT];
        st_nxt.mout_n = loopb ? 4'hf : ~st_r.mctl[3:0];
        st_nxt.serial_output    = loopb ? 1'b1 : TX_SHIFT_OUT;
        st_nxt.loopser = loopb ? TX_SHIFT_OUT : SERIAL_INPUT;
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_r        <= '0;
            st_r.mctl   <= uart_modem_pkg::MCTL_RST;
            st_r.ien    <= uart_modem_pkg::IEN_RST;
            st_r.lctl   <= uart_modem_pkg::LCTL_RST;
            st_r.div    <= uart_modem_pkg::DIV_RST;
            st_r.cnt    <= uart_modem_pkg::DIV_RST;
            st_r.thre   <= 1'b1;
            st_r.rd_s   <= 3'h7;
            st_r.wr_s   <= 3'h7;
            st_r.sync   <= 12'hfff;
            st_r.mout_n <= 4'hf;
            st_r.serial_output   <= 1'b1;
            st_r.loopser <= 1'b1;
        end else
            st_r <= st_nxt;
    end
    // ====================================================
    // Transmit queue and outputs
    assign txq.in_valid  = wr_p && ADDR == uart_modem_pkg::OFF_DATA && !divsel;
    assign txq.in_data   = DIN;
    assign txq.out_ready = TX_READY;
    assign TX_DATA   = txq.out_data;
    assign TX_VALID  = txq.out_valid;
    assign DOUT      = st_r.dout;
    assign DOUT_EN   = st_r.dout_en;
    assign DTR_N     = st_r.mout_n[0];
    assign RTS_N     = st_r.mout_n[1];
    assign FIRST_USER_OUTPUT_N    = st_r.mout_n[2];
    assign SECOND_USER_OUTPUT_N    = st_r.mout_n[3];
    assign INTR      = st_r.intr;
    assign BAUD_TICK = st_r.tick;
    assign SERIAL_OUTPUT = st_r.serial_output;
    assign LOOP_SERIAL   = st_r.loopser;
    assign RX_READ   = st_r.rx_read;
    // ====================================================
    // Checks
    dtr_drive_a: assert property (@(posedge CLK) disable iff (RST)
        !loopb |=> DTR_N == !$past(st_r.mctl[0]))
        else $error("dtr does not follow control");
    rts_drive_a: assert property (@(posedge CLK) disable iff (RST)
        !loopb |=> RTS_N == !$past(st_r.mctl[1]))
        else $error("rts does not follow control");
    intr_gate_a: assert property (@(posedge CLK) disable iff (RST)
        !st_r.mctl[3] |=> !INTR)
        else $error("interrupt not gated");
    loop_pins_a: assert property (@(posedge CLK) disable iff (RST)
        loopb |=> (st_r.mout_n == 4'hf) && SERIAL_OUTPUT)
        else $error("pins not parked in loopback");
    msr_clear_a: assert property (@(posedge CLK) disable iff (RST)
        rd_p && ADDR == uart_modem_pkg::OFF_MSTAT && chg == 4'h0
        && !wr_p |=> st_r.dmsr == 4'h0)
        else $error("change bits not cleared");
    iid_top_a: assert property (@(posedge CLK) disable iff (RST)
        pend[2] |-> top_id == 2'h3)
        else $error("line status not ranked first");
    intr_follow_a: assert property (@(posedge CLK) disable iff (RST)
        any_pend && st_r.mctl[3] |=> INTR)
        else $error("interrupt not raised");
    div_reload_a: assert property (@(posedge CLK) disable iff (RST)
        wr_p && divsel && ADDR == uart_modem_pkg::OFF_DATA
        |=> st_r.cnt == {st_r.div[15:8], $past(DIN)})
        else $error("divider not reloaded");
endmodule : uart_modem_irq_baud

// ---- verilog/uart_modem_pkg.sv ----
// Constants shared by the modem, interrupt and baud block.
// Assumes an 8-bit host bus with three address lines.
package uart_modem_pkg;
    // ====================================================
    // Register offsets
    localparam logic [2:0] OFF_DATA   = 3'h0;
    localparam logic [2:0] OFF_IEN    = 3'h1;
    localparam logic [2:0] OFF_IID    = 3'h2;
    localparam logic [2:0] OFF_LCTL   = 3'h3;
    localparam logic [2:0] OFF_MCTL   = 3'h4;
    localparam logic [2:0] OFF_LSTAT  = 3'h5;
    localparam logic [2:0] OFF_MSTAT  = 3'h6;
    localparam logic [2:0] OFF_SCR    = 3'h7;
    // ====================================================
    // Field positions
    localparam int MC_DTR   = 0;
    localparam int MC_RTS   = 1;
    localparam int MC_FIRST_USER_OUTPUT  = 2;
    localparam int MC_SECOND_USER_OUTPUT  = 3;
    localparam int MC_LOOP  = 4;
    localparam int LC_DIVSEL = 7;
    // ====================================================
    // Reset values
    localparam logic [7:0]  MCTL_RST  = 8'h00;
    localparam logic [7:0]  IEN_RST   = 8'h00;
    localparam logic [7:0]  LCTL_RST  = 8'h00;
    localparam logic [15:0] DIV_RST   = 16'h0001;
    // ====================================================
    // Identification codes
    localparam logic [1:0] ID_LINE  = 2'h3;
    localparam logic [1:0] ID_RXD   = 2'h2;
    localparam logic [1:0] ID_THRE  = 2'h1;
    localparam logic [1:0] ID_MODEM = 2'h0;
    // Fifo depth default
    localparam int FIFO_DEPTH = 16;
endpackage : uart_modem_pkg

// ---- verilog/fifo_if.sv ----
// Handshake carrier between the top block and its byte fifo.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface fifo_if #(parameter int W = 8);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport src (output in_valid, in_data, input in_ready,
                 input out_valid, out_data, output out_ready);
    modport fifo (input in_valid, in_data, output in_ready,
                  output out_valid, out_data, input out_ready);
endinterface : fifo_if

// ---- verilog/byte_fifo.sv ----
// Flip-flop fifo with valid and ready on both sides.
// Assumes a single clock and asynchronous active-high reset.
`timescale 1ns/100ps
module byte_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic CLK,
    input  wire logic RST,
    fifo_if.fifo      port
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("DEPTH must be a power of two");
    end
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } fifo_st_t;
    fifo_st_t st_r, st_nxt;
    logic push, pop;
    // ====================================================
    // Storage and pointers
    always_comb begin
        push = port.in_valid && (st_r.cnt != (AW+1)'(DEPTH));
        pop  = port.out_ready && (st_r.cnt != '0);
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = port.in_data;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop)
            st_nxt.rp = st_r.rp + 1'b1;
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign port.in_ready  = st_r.cnt != (AW+1)'(DEPTH);
    assign port.out_valid = st_r.cnt != '0;
    assign port.out_data  = st_r.mem[st_r.rp];
    count_range_a: assert property (@(posedge CLK) disable iff (RST)
        st_r.cnt <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule : byte_fifo

// ---- tb/modem_model.sv ----
// Modem model that drives the four status lines into the block.
// Assumes the bench sets the wanted line states, active high.
`timescale 1ns/100ps
module modem_model (
    input  wire logic       clk,
    input  wire logic [3:0] want,
    input  wire logic       slow,
    output logic            cts_n,
    output logic            dsr_n,
    output logic            ri_n,
    output logic            dcd_n
);
    // ====================================================
    // Line delay: one cycle when prompt, four when slow
    logic [15:0] line_r = 16'h0000;
    always_ff @(posedge clk) begin
        line_r <= {line_r[11:0], want};
    end
    // Active-low pins, order {dcd, ri, dsr, cts}
    assign {dcd_n, ri_n, dsr_n, cts_n} = slow ? ~line_r[15:12]
                                              : ~line_r[3:0];
endmodule : modem_model

// ---- tb/uart_modem_irq_baud_bench.sv ----
// Self-checking bench for the modem, interrupt and baud block.
// Assumes the package and design files are compiled first.
`timescale 1ns/100ps
module uart_modem_irq_baud_bench;
    logic       CLK, RST, RD_N, WR_N, DOUT_EN, INTR, BAUD_TICK;
    logic [2:0] ADDR;
    logic [7:0] DIN, DOUT, TX_DATA, RX_DATA, v, r;
    logic       CTS_N, DSR_N, RI_N, DCD_N, DTR_N, RTS_N, FIRST_USER_OUTPUT_N, SECOND_USER_OUTPUT_N;
    logic       SERIAL_INPUT, SERIAL_OUTPUT, LOOP_SERIAL, TX_SHIFT_OUT;
    logic       TX_VALID, TX_READY, TX_DONE, RX_AVAIL, RX_READ, slow;
    logic [3:0] RX_ERR, want, e;
    logic [7:0] q [16];
    int         err_total, n_compared, k, n, nrx;

    uart_modem_irq_baud dut_u (.CLK(CLK), .RST(RST), .ADDR(ADDR),
        .RD_N(RD_N), .WR_N(WR_N), .DIN(DIN), .DOUT(DOUT),
        .DOUT_EN(DOUT_EN), .CTS_N(CTS_N), .DSR_N(DSR_N), .RI_N(RI_N),
        .DCD_N(DCD_N), .DTR_N(DTR_N), .RTS_N(RTS_N), .FIRST_USER_OUTPUT_N(FIRST_USER_OUTPUT_N),
        .SECOND_USER_OUTPUT_N(SECOND_USER_OUTPUT_N), .INTR(INTR), .BAUD_TICK(BAUD_TICK),
        .SERIAL_INPUT(SERIAL_INPUT), .SERIAL_OUTPUT(SERIAL_OUTPUT),
        .LOOP_SERIAL(LOOP_SERIAL), .TX_SHIFT_OUT(TX_SHIFT_OUT),
        .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
        .TX_DONE(TX_DONE), .RX_AVAIL(RX_AVAIL), .RX_DATA(RX_DATA),
        .RX_ERR(RX_ERR), .RX_READ(RX_READ));
    modem_model modem_u (.clk(CLK), .want(want), .slow(slow),
        .cts_n(CTS_N), .dsr_n(DSR_N), .ri_n(RI_N), .dcd_n(DCD_N));

    // ====================================================
    // Clock, receive-read monitor, watchdog
    always #5 CLK = ~CLK;
    always @(posedge CLK) if (RX_READ === 1'b1) nrx++;
    initial begin
        repeat (30000) @(posedge CLK);
        err_total++;
        summarize();
    end

    // ====================================================
    // Host bus and compare tasks
    task automatic cyc(input int c);
        repeat (c) @(posedge CLK);
        #1;
    endtask : cyc
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        ADDR = a;
        DIN  = d;
        WR_N = 1'b0;
        cyc(6);
        WR_N = 1'b1;
        cyc(5);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        ADDR = a;
        RD_N = 1'b0;
        cyc(6);
        d    = DOUT;
        RD_N = 1'b1;
        cyc(5);
    endtask : rd
    task automatic chk(input logic [7:0] g, input logic [7:0] x,
                       input string m);
        n_compared++;
        if (g !== x) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, x);
        end
    endtask : chk
    task automatic rc(input logic [2:0] a, input logic [7:0] x,
                      input string m);
        logic [7:0] g;
        rd(a, g);
        chk(g, x, m);
    endtask : rc
    task automatic gap(output int c);
        c = 0;
        while (BAUD_TICK !== 1'b1 && c < 100) begin
            cyc(1);
            c++;
        end
        c = 0;
        do begin
            cyc(1);
            c++;
        end while (BAUD_TICK !== 1'b1 && c < 100);
    endtask : gap
    task automatic summarize;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // ====================================================
    // Scenarios
    initial begin
        {CLK, ADDR, DIN, want, slow, TX_READY, TX_DONE} = '0;
        {RX_AVAIL, RX_DATA, RX_ERR, err_total, n_compared, nrx} = '0;
        {RST, RD_N, WR_N, SERIAL_INPUT, TX_SHIFT_OUT} = 5'h1f;
        void'($urandom(32'h455727c1));
        repeat (16) @(posedge CLK);
        #1 RST = 1'b0;
        cyc(2);
        chk(8'({DTR_N, RTS_N, FIRST_USER_OUTPUT_N, SECOND_USER_OUTPUT_N, INTR, SERIAL_OUTPUT}),
            8'h3d, "reset pins");
        rc(uart_modem_pkg::OFF_IID, 8'h01, "iid idle");
        for (k = 0; k < 6; k++) begin
            v = 8'($urandom) & 8'he7;
            wr(uart_modem_pkg::OFF_MCTL, v);
            chk(8'({DTR_N, RTS_N}), 8'({~v[0], ~v[1]}), "dtr rts");
            rc(uart_modem_pkg::OFF_MCTL, v & 8'h07, "mctl rd");
        end
        wr(uart_modem_pkg::OFF_MCTL, 8'h08);
        wr(uart_modem_pkg::OFF_IEN, 8'h08);
        rd(uart_modem_pkg::OFF_MSTAT, r);
        for (k = 0; k < 8; k++) begin
            want[k%4] = (k < 4);
            slow = k[0];
            cyc(12);
            e = (k == 2) ? 4'h0 : 4'(1 << (k % 4));
            chk(8'(INTR), 8'(e != 4'h0), "intr");
            rc(uart_modem_pkg::OFF_IID, (e != 0) ? 8'h00 : 8'h01, "iid m");
            rc(uart_modem_pkg::OFF_MSTAT, {want, e}, "mstat");
            rc(uart_modem_pkg::OFF_MSTAT, {want, 4'h0}, "mstat clr");
        end
        wr(uart_modem_pkg::OFF_MCTL, 8'h00);
        want[0] = 1'b1;
        cyc(12);
        chk(8'(INTR), 8'h00, "intr gated");
        rc(uart_modem_pkg::OFF_IID, 8'h00, "iid gated");
        for (k = 0; k < 3; k++) begin
            v = 8'h18 | (8'($urandom) & 8'h07);
            wr(uart_modem_pkg::OFF_MCTL, v);
            want = 4'($urandom);
            TX_SHIFT_OUT = ~TX_SHIFT_OUT;
            SERIAL_INPUT = 1'($urandom);
            cyc(12);
            chk(8'({DTR_N, RTS_N, FIRST_USER_OUTPUT_N, SECOND_USER_OUTPUT_N, SERIAL_OUTPUT}), 8'h1f,
                "loop pins");
            chk(8'(LOOP_SERIAL), 8'(TX_SHIFT_OUT), "loop ser");
            rd(uart_modem_pkg::OFF_MSTAT, r);
            chk(r & 8'hf0, {v[3], v[2], v[0], v[1], 4'h0}, "loop ms");
            wr(uart_modem_pkg::OFF_MSTAT, 8'h05);
            rc(uart_modem_pkg::OFF_IID, 8'h00, "loop iid");
            rc(uart_modem_pkg::OFF_MSTAT, {r[7:4], 4'h5}, "loop wr");
        end
        wr(uart_modem_pkg::OFF_IEN, 8'hff);
        wr(uart_modem_pkg::OFF_MCTL, 8'h08);
        rc(uart_modem_pkg::OFF_IEN, 8'h0f, "ien");
        cyc(12);
        rd(uart_modem_pkg::OFF_MSTAT, r);
        want[0] = ~want[0];
        RX_ERR  = 4'h1;
        TX_DONE = 1'b1;
        RX_AVAIL = 1'b1;
        cyc(1);
        {RX_ERR, TX_DONE} = '0;
        cyc(12);
        rc(uart_modem_pkg::OFF_IID, 8'h06, "iid line");
        rd(uart_modem_pkg::OFF_LSTAT, r);
        chk(r & 8'h02, 8'h02, "overrun");
        rc(uart_modem_pkg::OFF_IID, 8'h04, "iid rxd");
        n = nrx;
        rd(uart_modem_pkg::OFF_DATA, r);
        chk(8'(nrx - n), 8'h01, "rx read");
        RX_AVAIL = 1'b0;
        cyc(4);
        rc(uart_modem_pkg::OFF_IID, 8'h02, "iid thre");
        rc(uart_modem_pkg::OFF_IID, 8'h00, "iid thre2");
        q[0] = 8'($urandom);
        wr(uart_modem_pkg::OFF_DATA, q[0]);
        rc(uart_modem_pkg::OFF_IID, 8'h00, "iid modem");
        rd(uart_modem_pkg::OFF_MSTAT, r);
        rc(uart_modem_pkg::OFF_IID, 8'h01, "iid none");
        for (k = 1; k < 17; k++) begin
            v = 8'($urandom);
            if (k < 16) q[k] = v;
            wr(uart_modem_pkg::OFF_DATA, v);
        end
        for (k = 0; k < 16; k++) begin
            chk(8'(TX_VALID), 8'h01, "fifo valid");
            chk(TX_DATA, q[k], "fifo data");
            TX_READY = 1'b1;
            cyc(1);
            TX_READY = 1'b0;
            cyc(1 + $urandom % 3);
        end
        chk(8'(TX_VALID), 8'h00, "fifo empty");
        wr(uart_modem_pkg::OFF_LCTL, 8'h80);
        for (k = 0; k < 2; k++) begin
            v = (k == 0) ? 8'h01 : 8'(2 + $urandom % 7);
            wr(uart_modem_pkg::OFF_DATA, v);
            wr(uart_modem_pkg::OFF_IEN, 8'h00);
            rc(uart_modem_pkg::OFF_DATA, v, "div lo");
            rc(uart_modem_pkg::OFF_IEN, 8'h00, "div hi");
            gap(n);
            chk(8'(n), v, "baud gap");
        end
        wr(uart_modem_pkg::OFF_LCTL, 8'h00);
        rc(uart_modem_pkg::OFF_IEN, 8'h0f, "ien back");
        summarize();
    end
endmodule : uart_modem_irq_baud_bench
